// ===== logic/sar_conversion_control.sv
`timescale 1ns/1ns
// Operation
// [R1] Host holds start-convert high at least 100 ns per conversion.
// [R2] Start high holds converter in reset, abandoning conversion.
// [R3] Falling edge of start begins a conversion.
// [R4] Eight parallel result bits held until next start command.
// [R5] Busy high during reset and conversion, low when result ready.
// [R6] Clock output: negative pulses gated on only during conversion.
// [R7] Serial output gives each bit decision in NRZ form.
// [R8] Each serial bit aligns with one clock output pulse.
// [R9] Unipolar: straight binary, positive true, all ones at FS-1LSB.
// [R10] Bipolar: offset binary, two's complement also available.
// [R11] Complemented MSB output turns offset binary into two's comp.
// [R12] Eight bits resolved, 256 codes.
// [R13] Two speed grades: 250 kHz or 500 kHz conversion rate.
// [R14] Range chosen by pin, not logic; coding follows it.
// [R15] One bit decided per clock pulse, MSB first to LSB.
module sar_conversion_control
  import sar_ctrl_pkg::*;
#(
  parameter int unsigned HALF_SLOW = HALF_SLOW_CYC,
  parameter int unsigned HALF_FAST = HALF_FAST_CYC
)
(
  // Clock and reset
  input  wire logic                clk_sys_in,
  input  wire logic                rst_n_in,
  // Host control
  input  wire logic                start_convert_in,
  input  wire logic                fast_grade_in,
  // Comparator decision for the current trial code
  input  wire logic                comp_above_in,
  // Trial code to the ladder
  output logic [RES_BITS-1:0]      trial_code_out,
  // Results
  output logic [RES_BITS-1:0]      result_out,
  output logic                     result_msb_n_out,
  // Status and serial link
  output logic                     busy_out,
  output logic                     serial_data_out,
  output logic                     clock_n_out
);

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  logic [1:0] start_sync_reg;
  logic [1:0] comp_sync_reg;
  logic [1:0] grade_sync_reg;
  logic       start_last_reg;
  logic       comp_sync;
  logic       fast_grade;
  logic       start_high;
  logic       start_fall;

  // Start pin and its edge history
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      start_sync_reg <= 2'h0;
      start_last_reg <= 1'b0;
    end
    else
    begin
      start_sync_reg <= {start_sync_reg[0], start_convert_in};
      start_last_reg <= start_sync_reg[1];
    end
  end

  // Comparator decision
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      comp_sync_reg <= 2'h0;
    end
    else
    begin
      comp_sync_reg <= {comp_sync_reg[0], comp_above_in};
    end
  end

  // Speed grade strap
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      grade_sync_reg <= 2'h0;
    end
    else
    begin
      grade_sync_reg <= {grade_sync_reg[0], fast_grade_in};
    end
  end

  assign start_high = start_sync_reg[1];
  assign comp_sync  = comp_sync_reg[1];
  assign fast_grade = grade_sync_reg[1];
  // Begin converting once the reset pulse ends
  assign start_fall = start_last_reg && !start_sync_reg[1]; // [R3]

  // ****************************************************************
  // Bit clock divider
  // ****************************************************************
  logic [HALF_CNT_WIDTH-1:0] half_cnt_reg;
  logic [HALF_CNT_WIDTH-1:0] half_cnt_next;
  logic [HALF_CNT_WIDTH-1:0] half_len;
  logic                      half_tick;
  logic                      phase_reg;
  logic                      phase_next;
  logic                      fall_tick;
  logic                      rise_tick;

  // Grade picks the bit period
  assign half_len = fast_grade                                 // [R13]
                  ? HALF_CNT_WIDTH'(HALF_FAST - 1)
                  : HALF_CNT_WIDTH'(HALF_SLOW - 1);

  seq_state_type state_reg;
  seq_state_type state_next;

  assign half_tick     = (half_cnt_reg == half_len);
  assign half_cnt_next = (state_reg != ST_CONV || half_tick)
                       ? '0
                       : half_cnt_reg + HALF_CNT_WIDTH'(1);
  // Phase 0 = clock high, phase 1 = clock low
  assign phase_next = (state_reg != ST_CONV) ? 1'b0
                    : (half_tick ? !phase_reg : phase_reg);
  assign fall_tick  = (state_reg == ST_CONV) && half_tick && !phase_reg;
  assign rise_tick  = (state_reg == ST_CONV) && half_tick && phase_reg;

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  logic [BIT_IDX_WIDTH-1:0] bit_idx_reg;
  logic [BIT_IDX_WIDTH-1:0] bit_idx_next;
  logic [RES_BITS-1:0]      trial_reg;
  logic [RES_BITS-1:0]      trial_next;
  logic [RES_BITS-1:0]      result_reg;
  logic [RES_BITS-1:0]      result_next;
  wire logic [RES_BITS-1:0] bit_mask;
  wire logic [RES_BITS-1:0] decided;
  logic                     decision;
  logic                     last_bit;
  logic                     serial_reg;
  logic                     serial_next;
  logic                     busy_reg;
  logic                     busy_next;
  logic                     clock_n_reg;
  logic                     clock_n_next;
  logic                     msb_n_reg;
  logic                     final_bit_reg;
  logic                     final_bit_next;

  // Range strap acts in the analog path; the comparator alone decides [R14]
  assign decision = comp_sync;
  assign last_bit = (bit_idx_reg == '0);

  // Bit under trial takes the decision; the others keep their value
  // Straight binary for unipolar, offset binary for bipolar [R9] [R10]
  for (genvar b = 0; b < RES_BITS; b++)
  begin : g_bit
    assign bit_mask[b] = (bit_idx_reg == BIT_IDX_WIDTH'(b));
    assign decided[b]  = bit_mask[b] ? decision : trial_reg[b];
  end

  always_comb
  begin
    state_next   = state_reg;
    bit_idx_next = bit_idx_reg;
    trial_next   = trial_reg;
    result_next  = result_reg;
    serial_next  = serial_reg;
    busy_next    = busy_reg;
    final_bit_next = final_bit_reg;
    case (state_reg)
      ST_IDLE:
      begin
        if (start_high)
        begin
          state_next = ST_HOLD;
          busy_next  = 1'b1;                                   // [R5]
        end
      end
      ST_HOLD:
      begin
        busy_next    = 1'b1;                                   // [R5]
        bit_idx_next = BIT_IDX_WIDTH'(RES_BITS - 1);           // [R12]
        trial_next   = RES_BITS'(1) << (RES_BITS - 1);         // [R15]
        final_bit_next = 1'b0;
        if (start_fall)
          state_next = ST_CONV;                                // [R3]
      end
      ST_CONV:
      begin
        if (fall_tick && !start_high)
        begin
          // Decide one bit per clock pulse, MSB first [R15]
          trial_next  = decided;
          serial_next = decision;                              // [R7] [R8]
          if (last_bit)
            final_bit_next = 1'b1;
          else
          begin
            bit_idx_next = bit_idx_reg - BIT_IDX_WIDTH'(1);
            trial_next   = decided | (bit_mask >> 1);
          end
        end
        // Finish as the clock pulse of the last decision ends [R8]
        if (rise_tick && final_bit_reg && !start_high)
        begin
          result_next = trial_reg;                             // [R4]
          busy_next   = 1'b0;                                  // [R5]
          state_next  = ST_IDLE;
        end
      end
      default:
      begin
        state_next = ST_IDLE;
      end
    endcase
    // Start high abandons any conversion and holds reset [R2]
    if (start_high)
    begin
      state_next = ST_HOLD;
      busy_next  = 1'b1;
    end
  end

  // Clock output low during the second half of each bit period
  assign clock_n_next = !((state_reg == ST_CONV) && phase_next   // [R6]
                        && !start_high);

  // ****************************************************************
  // Registers
  // ****************************************************************
  // Bit clock divider
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      half_cnt_reg <= '0;
      phase_reg    <= 1'b0;
    end
    else
    begin
      half_cnt_reg <= half_cnt_next;
      phase_reg    <= phase_next;
    end
  end

  // Sequencer state and trial code
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      state_reg     <= ST_IDLE;
      bit_idx_reg   <= '0;
      trial_reg     <= TRIAL_RESET;
      final_bit_reg <= 1'b0;
    end
    else
    begin
      state_reg     <= state_next;
      bit_idx_reg   <= bit_idx_next;
      trial_reg     <= trial_next;
      final_bit_reg <= final_bit_next;
    end
  end

  // Held result and its complemented top bit
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      result_reg <= RESULT_RESET;
      msb_n_reg  <= 1'b1;
    end
    else
    begin
      result_reg <= result_next;
      msb_n_reg  <= !result_next[RES_BITS-1];                  // [R11]
    end
  end

  // Status and serial link
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      serial_reg  <= 1'b0;
      busy_reg    <= 1'b0;
      clock_n_reg <= 1'b1;
    end
    else
    begin
      serial_reg  <= serial_next;
      busy_reg    <= busy_next;
      clock_n_reg <= clock_n_next;
    end
  end

  // ****************************************************************
  // Output words
  // ****************************************************************
  result_type   result_word;
  link_out_type link_word;

  assign result_word = '{data: result_reg, msb_n: msb_n_reg};  // [R4] [R11]
  assign link_word   = '{serial: serial_reg, clock_n: clock_n_reg,
                         busy: busy_reg};

  assign trial_code_out   = trial_reg;
  assign result_out       = result_word.data;
  assign result_msb_n_out = result_word.msb_n;
  assign busy_out         = link_word.busy;
  assign serial_data_out  = link_word.serial;
  assign clock_n_out      = link_word.clock_n;

endmodule // sar_conversion_control

// ===== include/sar_ctrl_pkg.sv
package sar_ctrl_pkg;

  // ****************************************************************
  // Converter geometry
  // ****************************************************************
  localparam int unsigned RES_BITS      = 8;
  localparam int unsigned CODE_COUNT    = 256;
  localparam int unsigned BIT_IDX_WIDTH = 3;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLK_SYS_MHZ   = 125;
  localparam int unsigned START_MIN_NS  = 100;
  // Shortest start pulse in system cycles (rounded up)
  localparam int unsigned START_MIN_CYC =
    (START_MIN_NS * CLK_SYS_MHZ + 999) / 1000;
  // Conversion rates of the two speed grades
  localparam int unsigned RATE_SLOW_KHZ = 250;
  localparam int unsigned RATE_FAST_KHZ = 500;
  // Conversion period per grade in system cycles (rounded down)
  localparam int unsigned CONV_SLOW_CYC =
    (CLK_SYS_MHZ * 1000) / RATE_SLOW_KHZ;
  localparam int unsigned CONV_FAST_CYC =
    (CLK_SYS_MHZ * 1000) / RATE_FAST_KHZ;
  // Half period of the internal bit clock: one conversion holds
  // RES_BITS bit periods plus one settling period
  localparam int unsigned HALF_SLOW_CYC =
    CONV_SLOW_CYC / ((RES_BITS + 1) * 2);
  localparam int unsigned HALF_FAST_CYC =
    CONV_FAST_CYC / ((RES_BITS + 1) * 2);
  localparam int unsigned HALF_CNT_WIDTH = 8;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [RES_BITS-1:0] RESULT_RESET = 8'h00;
  localparam logic [RES_BITS-1:0] TRIAL_RESET  = 8'h00;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_HOLD,
    ST_CONV
  } seq_state_type;

  typedef struct packed {
    logic [RES_BITS-1:0] data;
    logic                msb_n;
  } result_type;

  typedef struct packed {
    logic serial;
    logic clock_n;
    logic busy;
  } link_out_type;

endpackage

// ===== test/sar_comparator_model.sv
`timescale 1ns/1ns
module sar_comparator_model
  import sar_ctrl_pkg::*;
#(
  parameter int unsigned SETTLE_NS = 0
)
(
  // Ladder and analog level
  input  wire logic [RES_BITS-1:0] trial_code_in,
  input  wire logic [RES_BITS-1:0] level_in,
  // Decision
  output logic                     comp_above_out
);
  // Input at or above trial code; range fixed by the level fed
  assign #(SETTLE_NS) comp_above_out = level_in >= trial_code_in;
endmodule // sar_comparator_model

// ===== test/sar_conversion_control_asserts.sv
`timescale 1ns/1ns
module sar_conversion_control_asserts
  import sar_ctrl_pkg::*;
#(
  parameter int unsigned HALF_SLOW = HALF_SLOW_CYC,
  parameter int unsigned HALF_FAST = HALF_FAST_CYC
)
(
  // Clock, reset and inputs
  input wire logic                clk_sys_in,
  input wire logic                rst_n_in,
  input wire logic                start_convert_in,
  input wire logic                fast_grade_in,
  input wire logic                comp_above_in,
  // Outputs
  input wire logic [RES_BITS-1:0] trial_code_out,
  input wire logic [RES_BITS-1:0] result_out,
  input wire logic                result_msb_n_out,
  input wire logic                busy_out,
  input wire logic                serial_data_out,
  input wire logic                clock_n_out
);
  // ****
  // Sequences and properties
  // ****
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_hold;
    start_convert_in [*5]; endsequence
  sequence s_launch;
    s_hold ##1 !start_convert_in; endsequence
  property p_busy_rise;
    $rose(start_convert_in) |-> ##[1:4] busy_out; endproperty
  a_busy_rise: assert property (p_busy_rise) else $error("busy late");
  property p_hold;
    s_hold |-> busy_out && clock_n_out; endproperty
  a_hold: assert property (p_hold) else $error("not held");
  property p_conv_busy;
    s_launch |-> busy_out [*8]; endproperty
  a_conv_busy: assert property (p_conv_busy) else $error("busy gap");
  // Conversion length window over both speed grades
  localparam int CONV_MIN = 15 * HALF_FAST;
  localparam int CONV_MAX = 18 * HALF_SLOW + 6;
  property p_conv_end;
    s_launch |-> ##[CONV_MIN:CONV_MAX] (!busy_out || start_convert_in);
  endproperty
  a_conv_end: assert property (p_conv_end) else $error("no end");
  property p_result_held;
    $changed(result_out) |-> $fell(busy_out); endproperty
  a_result_held: assert property (p_result_held) else $error("moved");
  property p_msb_n;
    result_msb_n_out == !result_out[RES_BITS-1]; endproperty
  a_msb_n: assert property (p_msb_n) else $error("msb_n wrong");
  property p_clock_idle;
    !busy_out |-> clock_n_out; endproperty
  a_clock_idle: assert property (p_clock_idle) else $error("clock on");
  property p_serial_align;
    $changed(serial_data_out) |-> $fell(clock_n_out) || $fell(busy_out);
  endproperty
  a_serial_align: assert property (p_serial_align) else $error("skew");
endmodule // sar_conversion_control_asserts

bind sar_conversion_control sar_conversion_control_asserts #(
  .HALF_SLOW(HALF_SLOW),
  .HALF_FAST(HALF_FAST)
) sar_conversion_control_asserts_i (.clk_sys_in, .rst_n_in,
  .start_convert_in, .fast_grade_in, .comp_above_in, .trial_code_out,
  .result_out, .result_msb_n_out, .busy_out, .serial_data_out,
  .clock_n_out);

// ===== test/tb_sar_conversion_control.sv
`timescale 1ns/1ns
module tb_sar_conversion_control;
  import sar_ctrl_pkg::*;
  localparam int unsigned HS = 3;
  localparam int unsigned HF = 2;
  logic                clk_sys_in = 1'b0;
  logic                rst_n_in = 1'b0;
  logic                start_convert_in = 1'b0;
  logic                fast_grade_in = 1'b0;
  logic                comp_above_in;
  logic [RES_BITS-1:0] level = 8'h00;
  logic [RES_BITS-1:0] expect_res = RESULT_RESET;
  logic [RES_BITS-1:0] trial_code_out;
  logic [RES_BITS-1:0] result_out;
  logic                result_msb_n_out;
  logic                busy_out;
  logic                serial_data_out;
  logic                clock_n_out;
  int                  err_count = 0;
  int                  samples_checked = 0;
  // ****
  // Design and comparator
  // ****
  sar_conversion_control #(.HALF_SLOW(HS), .HALF_FAST(HF))
    sar_conversion_control_i (.clk_sys_in, .rst_n_in, .start_convert_in,
    .fast_grade_in, .comp_above_in, .trial_code_out, .result_out,
    .result_msb_n_out, .busy_out, .serial_data_out, .clock_n_out);
  sar_comparator_model #(.SETTLE_NS(3)) sar_comparator_model_i (
    .trial_code_in(trial_code_out), .level_in(level),
    .comp_above_out(comp_above_in));
  initial
  begin
    forever #4 clk_sys_in = ~clk_sys_in;
  end
  // ****
  // Checking and tests
  // ****
  task automatic chk(input string what, input logic [7:0] seen, exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic conv(input logic [RES_BITS-1:0] lvl, input logic fst);
    int n;
    int bits;
    int half;
    logic [RES_BITS-1:0] sr;
    logic pc;
    logic pb;
    half = fst ? HF : HS;
    level = lvl;
    fast_grade_in = fst;
    start_convert_in = 1'b1;
    repeat (START_MIN_CYC) @(negedge clk_sys_in);
    chk("hold busy", 8'(busy_out), 8'h01);
    chk("hold clock", 8'(clock_n_out), 8'h01);
    chk("held result", result_out, expect_res);
    start_convert_in = 1'b0;
    bits = 0;
    sr = 8'h00;
    pc = 1'b1;
    pb = 1'b1;
    for (n = 0; n < 200 && pb; n++)
    begin
      @(negedge clk_sys_in);
      if ((pc && !clock_n_out) || (!busy_out && bits < 8))
      begin
        sr = {sr[RES_BITS-2:0], serial_data_out};
        bits++;
      end
      pc = clock_n_out;
      pb = busy_out;
    end
    if (pb)
    begin
      chk("busy end", 8'(pb), 8'h00);
      summarize();
    end
    expect_res = lvl;
    chk("result", result_out, lvl);
    chk("msb_n", 8'(result_msb_n_out), 8'(!lvl[7]));
    chk("serial", sr, lvl);
    chk("trial", trial_code_out, lvl);
    chk("bits", 8'(bits), 8'h08);
    chk("length", 8'(n >= 16 * half && n <= 18 * half + 6), 8'h01);
  endtask
  task automatic t_codes;
    logic [RES_BITS-1:0] codes [6] = '{8'h00, 8'hFF, 8'h80, 8'h7F,
                                       8'hA5, 8'h5A};
    for (int i = 0; i < 6; i++)
      conv(codes[i], i[0]);
    $display("codes test done");
  endtask
  task automatic t_abort;
    level = 8'h3C;
    start_convert_in = 1'b1;
    repeat (START_MIN_CYC) @(negedge clk_sys_in);
    start_convert_in = 1'b0;
    repeat (20) @(negedge clk_sys_in);
    chk("busy mid", 8'(busy_out), 8'h01);
    conv(8'hC3, 1'b0);
    $display("abort test done");
  endtask
  task automatic t_idle;
    repeat (30)
    begin
      @(negedge clk_sys_in);
      chk("idle clock", 8'(clock_n_out), 8'h01);
      chk("idle result", result_out, expect_res);
    end
    $display("idle test done");
  endtask
  initial
  begin
    repeat (4) @(negedge clk_sys_in);
    rst_n_in = 1'b1;
    t_codes();
    t_abort();
    t_idle();
    summarize();
  end
endmodule // tb_sar_conversion_control
